// [lpc_consts.svh]
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH

// ==========================================================
// Register offsets
`define LPC_OFF_CTRL   6'h01
`define LPC_OFF_MASK0  6'h13
`define LPC_OFF_MASK1  6'h14
`define LPC_OFF_STAT0  6'h18
`define LPC_OFF_STAT1  6'h19
`define LPC_OFF_GCFG   6'h20

// ==========================================================
// Reset values
`define LPC_CTRL_RST   8'h00
`define LPC_MASK_RST   8'hFF
`define LPC_STAT_RST   8'h00
`define LPC_GCFG_RST   8'h01
`define LPC_RDATA_RST  8'h00

// ==========================================================
// Field positions
`define LPC_CTRL_EDGE     0
`define LPC_CTRL_PATH_LO  1
`define LPC_CTRL_LOOP_LO  3
`define LPC_CTRL_INBAND   5
`define LPC_GCFG_GMASK    0
`define LPC_GCFG_POL      1

// ==========================================================
// Serial frame
`define LPC_SER_LAST_BIT  3'h7

`endif

// [lpc_pkg.sv]
package lpc_pkg;

  typedef enum logic [1:0] {
    LPC_HW      = 2'b00,
    LPC_SERIAL  = 2'b01,
    LPC_PAR_RW  = 2'b10,
    LPC_PAR_STB = 2'b11
  } lpc_mode_t;

  typedef enum logic [1:0] {
    LPC_SER_CMD  = 2'b00,
    LPC_SER_LOAD = 2'b01,
    LPC_SER_DATA = 2'b10,
    LPC_SER_DONE = 2'b11
  } lpc_ser_st_t;

  typedef struct packed {
    lpc_ser_st_t state;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic [5:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rdd;
    logic        sclk_q;
    logic [7:0]  sdo_sh;
    logic        sdo;
    logic        oe;
  } lpc_ser_t;

  typedef struct packed {
    lpc_mode_t   mode;
    logic [7:0]  ctrl;
    logic [7:0]  gcfg;
    logic [15:0] mask;
    logic [15:0] stat;
    logic        clk_q;
    logic        rail_p;
    logic        rail_n;
    logic [1:0]  path;
    logic [1:0]  loop;
    logic        inband;
    logic        irq;
    logic        wr_q;
    logic        rd_q;
    logic [5:0]  rd_addr;
    logic [7:0]  rdata;
    logic        rdata_oe;
  } lpc_state_t;

endpackage

// [lpc_serial_port.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lpc_consts.svh"

module lpc_serial_port
  import lpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       en_i,
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sclke_i,
  input  wire logic       sdi_i,
  input  wire logic [7:0] rdata_i,
  output logic      [5:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_done_o,
  output logic            sdo_o,
  output logic            sdo_oe_o
);

  lpc_ser_t st;
  lpc_ser_t next_st;
  logic     rise;
  logic     act;
  logic [7:0] word;

  // ========================================================
  // Frame: 8 command bits (rw, addr[5:0], spare) then 8 data bits
  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.rdd = 1'b0;
    next_st.sclk_q = sclk_i;
    rise = sclk_i && !st.sclk_q;
    act = sclke_i ? (!sclk_i && st.sclk_q) : rise;
    word = {sdi_i, st.sh[7:1]};
    if (!en_i || cs_n_i) begin
      next_st.state = LPC_SER_CMD;
      next_st.cnt = 3'h0;
      next_st.oe = 1'b0;
    end else begin
      case (st.state)
        LPC_SER_CMD: begin
          if (rise) begin
            next_st.sh = word;
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == `LPC_SER_LAST_BIT) begin
              next_st.rw = word[0];
              next_st.addr = word[6:1];
              next_st.state = LPC_SER_LOAD;
            end
          end
        end
        LPC_SER_LOAD: begin
          next_st.sdo_sh = rdata_i;
          next_st.sdo = rdata_i[0];
          next_st.oe = st.rw;
          next_st.state = LPC_SER_DATA;
        end
        LPC_SER_DATA: begin
          // Falling-edge mode keeps bit 0 up until the first data rise
          if (act && st.rw && (!sclke_i || st.cnt != 3'h0)) begin
            next_st.sdo_sh = {1'b0, st.sdo_sh[7:1]};
            next_st.sdo = st.sdo_sh[1];
          end
          if (rise) begin
            next_st.sh = word;
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == `LPC_SER_LAST_BIT) begin
              next_st.state = LPC_SER_DONE;
              next_st.wdata = word;
              next_st.wr = !st.rw;
              next_st.rdd = st.rw;
            end
          end
        end
        LPC_SER_DONE: begin
          next_st.oe = 1'b0;
        end
        default: begin
          next_st.state = LPC_SER_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign addr_o    = st.addr;
  assign wdata_o   = st.wdata;
  assign wr_o      = st.wr;
  assign rd_done_o = st.rdd;
  assign sdo_o     = st.sdo;
  assign sdo_oe_o  = st.oe;

  a_ser_cs_idle: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cs_n_i |=> !sdo_oe_o && !wr_o)
    else $error("serial port active with chip select high");

endmodule
`default_nettype wire

// [lpc_pin_ctrl.sv]
// Functional notes
// - Two select pins choose hardware, serial, parallel R/W or strobe control.
// - Hardware mode: edge strap low updates rails on rising, high on falling.
// - Path strap 00 single rail HDB3/B8ZS, 01 single rail AMI.
// - Path strap 10 dual rail with recovery, 11 slicer with recovery bypassed.
// - Host holds chip select low; interfaces answer only while it is low.
// - Hardware mode loopback straps: 00 none, 01 analog, 10 digital, 11 remote.
// - Inband loopback only under software control, never from straps.
// - One interrupt output combines every source of both channels.
// - Global mask bit at one blocks all sources from the interrupt output.
// - Each source has its own mask bit in registers 13H and 14H.
// - Pending sources show in status registers 18H and 19H.
// - Interrupt output is push-pull, polarity selectable high or low.
`timescale 1ns/1ns
`default_nettype none
`include "lpc_consts.svh"

module lpc_pin_ctrl
  import lpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [1:0]  mode_sel_i,
  input  wire logic        rx_edge_strap_i,
  input  wire logic [1:0]  path_mode_strap_i,
  input  wire logic        ch1_loop_sel_hi_i,
  input  wire logic        ch1_loop_sel_lo_i,
  input  wire logic        recovered_rx_clock_i,
  input  wire logic        rx_pos_data_i,
  input  wire logic        rx_neg_data_i,
  input  wire logic [15:0] int_src_i,
  input  wire logic        cs_n_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        ds_rd_n_i,
  input  wire logic        rw_wr_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sclke_i,
  input  wire logic        sdi_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic             rx_positive_rail_o,
  output logic             rx_negative_rail_o,
  output logic      [1:0]  path_mode_o,
  output logic      [1:0]  ch1_loop_mode_o,
  output logic             inband_loop_o,
  output logic             irq_o
);

  lpc_state_t  st;
  lpc_state_t  next_st;
  logic        hw;
  logic        sel;
  logic        rd_act;
  logic        wr_act;
  logic        wr_go;
  logic [5:0]  wa;
  logic [7:0]  wd;
  logic        clr_go;
  logic [5:0]  ca;
  logic [15:0] clr;
  logic        edge_hit;
  logic        pend;
  logic [5:0]  ser_addr;
  logic [7:0]  ser_wdata;
  logic        ser_wr;
  logic        ser_rd;

  // ========================================================
  // Register read view
  function automatic logic [7:0] rd_mux(input lpc_state_t s,
                                        input logic [5:0] a);
    case (a)
      `LPC_OFF_CTRL:  rd_mux = s.ctrl;
      `LPC_OFF_MASK0: rd_mux = s.mask[7:0];
      `LPC_OFF_MASK1: rd_mux = s.mask[15:8];
      `LPC_OFF_STAT0: rd_mux = s.stat[7:0];
      `LPC_OFF_STAT1: rd_mux = s.stat[15:8];
      `LPC_OFF_GCFG:  rd_mux = s.gcfg;
      default:        rd_mux = 8'h00;
    endcase
  endfunction

  // ========================================================
  // Serial port
  lpc_serial_port u_serial (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .en_i      (st.mode == LPC_SERIAL),
    .cs_n_i    (cs_n_i),
    .sclk_i    (sclk_i),
    .sclke_i   (sclke_i),
    .sdi_i     (sdi_i),
    .rdata_i   (rd_mux(st, ser_addr)),
    .addr_o    (ser_addr),
    .wdata_o   (ser_wdata),
    .wr_o      (ser_wr),
    .rd_done_o (ser_rd),
    .sdo_o     (sdo_o),
    .sdo_oe_o  (sdo_oe_o)
  );

  // ========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.mode = lpc_mode_t'(mode_sel_i);
    hw = (st.mode == LPC_HW);
    sel = !cs_n_i &&
          (st.mode == LPC_PAR_RW || st.mode == LPC_PAR_STB);
    if (st.mode == LPC_PAR_RW) begin
      rd_act = sel && !ds_rd_n_i && rw_wr_n_i;
      wr_act = sel && !ds_rd_n_i && !rw_wr_n_i;
    end else begin
      rd_act = sel && !ds_rd_n_i;
      wr_act = sel && !rw_wr_n_i;
    end
    next_st.wr_q = wr_act;
    next_st.rd_q = rd_act;
    // Writes land on the leading edge of the parallel strobe
    wr_go = (wr_act && !st.wr_q) || ser_wr;
    wa = ser_wr ? ser_addr : addr_i;
    wd = ser_wr ? ser_wdata : data_i;
    if (wr_go) begin
      case (wa)
        `LPC_OFF_CTRL:  next_st.ctrl = wd;
        `LPC_OFF_MASK0: next_st.mask[7:0] = wd;
        `LPC_OFF_MASK1: next_st.mask[15:8] = wd;
        `LPC_OFF_GCFG:  next_st.gcfg = wd;
        default: begin
        end
      endcase
    end
    // Status clears when a read of it completes; new events still win
    if (rd_act) begin
      next_st.rd_addr = addr_i;
    end
    clr_go = (st.rd_q && !rd_act) || ser_rd;
    ca = ser_rd ? ser_addr : st.rd_addr;
    clr = 16'h0000;
    if (clr_go && ca == `LPC_OFF_STAT0) begin
      clr[7:0] = 8'hFF;
    end
    if (clr_go && ca == `LPC_OFF_STAT1) begin
      clr[15:8] = 8'hFF;
    end
    next_st.stat = (st.stat & ~clr) | int_src_i;
    next_st.rdata = rd_act ? rd_mux(st, addr_i) : `LPC_RDATA_RST;
    next_st.rdata_oe = rd_act;
    // Interrupt combine, masks and polarity
    pend = (|(st.stat & ~st.mask)) &&
           !st.gcfg[`LPC_GCFG_GMASK];
    next_st.irq = st.gcfg[`LPC_GCFG_POL] ? pend : !pend;
    // Strap or register sourced line configuration
    if (hw) begin
      next_st.path = path_mode_strap_i;
      next_st.loop = {ch1_loop_sel_hi_i, ch1_loop_sel_lo_i};
      next_st.inband = 1'b0;
    end else begin
      next_st.path = st.ctrl[`LPC_CTRL_PATH_LO +: 2];
      next_st.loop = st.ctrl[`LPC_CTRL_LOOP_LO +: 2];
      next_st.inband = st.ctrl[`LPC_CTRL_INBAND];
    end
    // Rail update on the chosen edge of the recovered clock
    next_st.clk_q = recovered_rx_clock_i;
    if (hw ? rx_edge_strap_i : st.ctrl[`LPC_CTRL_EDGE]) begin
      edge_hit = st.clk_q && !recovered_rx_clock_i;
    end else begin
      edge_hit = !st.clk_q && recovered_rx_clock_i;
    end
    if (edge_hit) begin
      next_st.rail_p = rx_pos_data_i;
      next_st.rail_n = rx_neg_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.mode <= LPC_HW;
      st.ctrl <= `LPC_CTRL_RST;
      st.gcfg <= `LPC_GCFG_RST;
      st.mask <= {`LPC_MASK_RST, `LPC_MASK_RST};
      st.stat <= {`LPC_STAT_RST, `LPC_STAT_RST};
      st.irq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign data_o             = st.rdata;
  assign data_oe_o          = st.rdata_oe;
  assign rx_positive_rail_o = st.rail_p;
  assign rx_negative_rail_o = st.rail_n;
  assign path_mode_o        = st.path;
  assign ch1_loop_mode_o    = st.loop;
  assign inband_loop_o      = st.inband;
  assign irq_o              = st.irq;

  // ========================================================
  // Checks
  a_mode_follow: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ##1 st.mode == lpc_mode_t'($past(mode_sel_i)))
    else $error("control mode does not follow select pins");

  a_edge_rise: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (hw && !rx_edge_strap_i && !st.clk_q && recovered_rx_clock_i)
    |=> rx_positive_rail_o == $past(rx_pos_data_i))
    else $error("rail not updated on rising receive clock");

  a_edge_fall: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (hw && rx_edge_strap_i && !st.clk_q && recovered_rx_clock_i)
    |=> $stable(rx_negative_rail_o))
    else $error("rail changed on rising edge in falling mode");

  a_path_hw: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hw |=> path_mode_o == $past(path_mode_strap_i))
    else $error("path mode does not follow strap");

  a_path_slicer: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (hw && path_mode_strap_i == 2'h3) ##1 1'b1 |-> path_mode_o == 2'h3)
    else $error("slicer mode not selected");

  a_par_cs_idle: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cs_n_i |=> !data_oe_o)
    else $error("parallel bus driven with chip select high");

  a_loop_hw: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hw |=> ch1_loop_mode_o ==
           $past({ch1_loop_sel_hi_i, ch1_loop_sel_lo_i}))
    else $error("loopback does not follow straps");

  a_inband_hw: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hw |=> !inband_loop_o)
    else $error("inband loopback in hardware mode");

  a_irq_any: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (!st.gcfg[`LPC_GCFG_GMASK] && |(st.stat & ~st.mask))
    |=> irq_o == $past(st.gcfg[`LPC_GCFG_POL]))
    else $error("pending unmasked source not signalled");

  a_gmask_all: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    st.gcfg[`LPC_GCFG_GMASK] |=> irq_o != $past(st.gcfg[`LPC_GCFG_POL]))
    else $error("global mask did not block interrupt");

  a_stat_set: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    int_src_i[0] |=> st.stat[0] ##1 (st.stat[0] || $past(clr_go)))
    else $error("status bit not captured");

  a_irq_clear: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (~|(st.stat & ~st.mask)) |=> irq_o != $past(st.gcfg[`LPC_GCFG_POL]))
    else $error("interrupt held with nothing pending");

endmodule
`default_nettype wire

// [lpc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Host side of the parallel and serial ports
module lpc_host_model
  import lpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  input  wire logic       data_oe_i,
  input  wire logic       sdo_i,
  input  wire logic       sdo_oe_i,
  output logic            sclk_o,
  output logic            sclke_o,
  output logic            sdi_o,
  output logic      [1:0] mode_sel_o,
  output logic            cs_n_o,
  output logic      [5:0] addr_o,
  output logic      [7:0] data_o,
  output logic            ds_rd_n_o,
  output logic            rw_wr_n_o
);
  initial begin
    mode_sel_o = LPC_HW;
    cs_n_o     = 1'b1;
    addr_o     = 6'h00;
    data_o     = 8'h00;
    ds_rd_n_o  = 1'b1;
    rw_wr_n_o  = 1'b1;
    sclk_o     = 1'b0;
    sclke_o    = 1'b0;
    sdi_o      = 1'b0;
  end

  task automatic set_mode(input lpc_mode_t m);
    @(negedge clk_i);
    mode_sel_o = m;
  endtask

  task automatic acc(input logic wr, input logic [5:0] a,
                     input logic [7:0] d, input logic sel,
                     output logic [7:0] q, output logic oe);
    @(negedge clk_i);
    cs_n_o = !sel;
    addr_o = a;
    data_o = d;
    if (mode_sel_o == LPC_PAR_RW) begin
      ds_rd_n_o = 1'b0;
      rw_wr_n_o = !wr;
    end else if (wr) begin
      rw_wr_n_o = 1'b0;
    end else begin
      ds_rd_n_o = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    q = data_i;
    oe = data_oe_i;
    cs_n_o    = 1'b1;
    ds_rd_n_o = 1'b1;
    rw_wr_n_o = 1'b1;
    // Released bus does not keep its last value
    addr_o = ~addr_o;
    data_o = ~data_o;
    repeat (2) @(negedge clk_i);
  endtask

  // Serial frame: rw, addr, spare, then data, all LSB first
  task automatic ser(input logic wr, input logic [5:0] a,
                     input logic [7:0] d, input logic fe,
                     output logic [7:0] q, output logic oe);
    logic [15:0] f;
    f = {d, 1'b0, a, !wr};
    q = 8'h00;
    oe = 1'b0;
    @(negedge clk_i);
    sclke_o = fe;
    cs_n_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi_o = f[i];
      repeat (3) @(negedge clk_i);
      sclk_o = 1'b1;
      // Sample on the edge opposite to the one that shifts
      if (fe && i >= 8) q[i - 8] = sdo_i;
      if (i == 10) oe = sdo_oe_i;
      repeat (3) @(negedge clk_i);
      sclk_o = 1'b0;
      if (!fe && i >= 7 && i < 15) q[i - 7] = sdo_i;
    end
    repeat (3) @(negedge clk_i);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

`default_nettype wire

// [liu_pin_config_and_interrupt_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module liu_pin_config_and_interrupt_tb;
  import lpc_pkg::*;
  logic        clk_i, resetn_i, edge_s, lhi, llo, rclk, rpos, rneg;
  logic [1:0]  path_s, mode, path_o, loop_o;
  logic [15:0] src, m_mask, m_stat;
  logic [7:0]  wdat, rdat, m_ctrl, m_gcfg;
  logic [5:0]  addr;
  logic        cs_n, ds_n, rw_n, rp_o, rn_o, inb_o, irq_o, ep, en;
  logic        sclk, sclke, sdi, sdo, sdo_oe, doe;
  logic [5:0]  adr [7];
  int          num_errors, num_checks, b;

  lpc_host_model host_u (.clk_i(clk_i), .data_i(rdat),
    .mode_sel_o(mode), .cs_n_o(cs_n), .addr_o(addr), .data_o(wdat),
    .ds_rd_n_o(ds_n), .rw_wr_n_o(rw_n), .data_oe_i(doe),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .sclke_o(sclke),
    .sdi_o(sdi));

  lpc_pin_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .mode_sel_i(mode), .rx_edge_strap_i(edge_s),
    .path_mode_strap_i(path_s), .ch1_loop_sel_hi_i(lhi),
    .ch1_loop_sel_lo_i(llo), .recovered_rx_clock_i(rclk),
    .rx_pos_data_i(rpos), .rx_neg_data_i(rneg), .int_src_i(src),
    .cs_n_i(cs_n), .addr_i(addr), .data_i(wdat), .ds_rd_n_i(ds_n),
    .rw_wr_n_i(rw_n), .sclk_i(sclk), .sclke_i(sclke), .sdi_i(sdi),
    .data_o(rdat), .data_oe_o(doe), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .rx_positive_rail_o(rp_o), .rx_negative_rail_o(rn_o),
    .path_mode_o(path_o), .ch1_loop_mode_o(loop_o),
    .inband_loop_o(inb_o), .irq_o(irq_o));

  // ==========================================================
  // Checking and model helpers
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic sel = 1'b1, input logic s = 1'b0,
                    input logic fe = 1'b0);
    logic [7:0] q;
    logic       oe;
    if (s) host_u.ser(1'b1, a, d, fe, q, oe);
    else host_u.acc(1'b1, a, d, sel, q, oe);
    chk("bus_oe", 16'h0000, {15'h0000, oe});
    if (sel) begin
      case (a)
        6'h01:   m_ctrl = d;
        6'h13:   m_mask[7:0] = d;
        6'h14:   m_mask[15:8] = d;
        6'h20:   m_gcfg = d;
        default: ;
      endcase
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic s = 1'b0,
                    input logic fe = 1'b0);
    logic [7:0] q, e;
    logic       oe;
    if (s) host_u.ser(1'b0, a, 8'h00, fe, q, oe);
    else host_u.acc(1'b0, a, 8'h00, 1'b1, q, oe);
    chk("bus_oe", 16'h0001, {15'h0000, oe});
    case (a)
      6'h01:   e = m_ctrl;
      6'h13:   e = m_mask[7:0];
      6'h14:   e = m_mask[15:8];
      6'h18:   begin e = m_stat[7:0]; m_stat[7:0] = 8'h00; end
      6'h19:   begin e = m_stat[15:8]; m_stat[15:8] = 8'h00; end
      6'h20:   e = m_gcfg;
      default: e = 8'h00;
    endcase
    chk("rdata", {8'h00, e}, {8'h00, q});
  endtask

  task automatic pulse(input logic [15:0] v);
    @(negedge clk_i);
    src = v;
    @(negedge clk_i);
    src = 16'h0000;
    m_stat = m_stat | v;
  endtask

  task automatic ck_irq();
    logic p;
    cyc(3);
    p = (|(m_stat & ~m_mask)) && !m_gcfg[0];
    chk("irq", {15'h0000, m_gcfg[1] ? p : !p}, {15'h0000, irq_o});
  endtask

  task automatic cfg(input logic [1:0] p, input logic [1:0] l,
                     input logic i);
    cyc(3);
    chk("path", {14'h0000, p}, {14'h0000, path_o});
    chk("loop", {14'h0000, l}, {14'h0000, loop_o});
    chk("inband", {15'h0000, i}, {15'h0000, inb_o});
  endtask

  task automatic rstep(input logic v);
    @(negedge clk_i);
    rpos = 1'($urandom);
    rneg = 1'($urandom);
    cyc(1);
    rclk = v;
    if (v != edge_s) begin
      ep = rpos;
      en = rneg;
    end
    cyc(4);
    chk("rail_p", {15'h0000, ep}, {15'h0000, rp_o});
    chk("rail_n", {15'h0000, en}, {15'h0000, rn_o});
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial begin
    resetn_i = 1'b0;
    {edge_s, lhi, llo, rclk, rpos, rneg, ep, en} = 8'h00;
    path_s = 2'b00;
    src = 16'h0000;
    m_ctrl = 8'h00;
    m_mask = 16'hFFFF;
    m_stat = 16'h0000;
    m_gcfg = 8'h01;
    num_errors = 0;
    num_checks = 0;
    adr = '{6'h01, 6'h13, 6'h14, 6'h18, 6'h19, 6'h20, 6'h3F};
    void'($urandom(76));
    cyc(5);
    resetn_i = 1'b1;
    cyc(2);
    chk("irq_rst", 16'h0001, {15'h0000, irq_o});
    host_u.set_mode(LPC_PAR_RW);
    cyc(3);
    wr(6'h18, 8'hFF);
    wr(6'h3F, 8'h55);
    wr(6'h13, 8'h00, 1'b0);
    foreach (adr[i]) rd(adr[i]);
    $display("test registers done");
    path_s = 2'b01;
    lhi = 1'b1;
    wr(6'h01, 8'h2D);
    cfg(2'b10, 2'b01, 1'b1);
    $display("test software config done");
    wr(6'h20, 8'h02);
    wr(6'h13, 8'hFE);
    pulse(16'h0003); ck_irq();
    rd(6'h18); ck_irq();
    pulse(16'h0002); ck_irq();
    rd(6'h18);
    b = 8 + int'($urandom % 8);
    wr(6'h14, ~(8'h01 << (b - 8)));
    pulse(16'h0001 << b); ck_irq();
    rd(6'h19); ck_irq();
    wr(6'h20, 8'h03);
    pulse(16'h0001); ck_irq();
    wr(6'h20, 8'h02); ck_irq();
    rd(6'h18);
    wr(6'h20, 8'h00); ck_irq();
    pulse(16'h0001); ck_irq();
    rd(6'h18); ck_irq();
    $display("test interrupts done");
    host_u.set_mode(LPC_PAR_STB);
    cyc(3);
    wr(6'h13, 8'h5A);
    rd(6'h13);
    wr(6'h13, 8'h00, 1'b0);
    rd(6'h13);
    $display("test strobe port done");
    host_u.set_mode(LPC_SERIAL);
    cyc(3);
    wr(6'h13, 8'($urandom), 1'b1, 1'b1, 1'b0);
    rd(6'h13, 1'b1, 1'b0);
    rd(6'h13, 1'b1, 1'b1);
    pulse(16'h00A5);
    rd(6'h18, 1'b1, 1'b1);
    rd(6'h18, 1'b1, 1'b0);
    $display("test serial port done");
    host_u.set_mode(LPC_HW);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      path_s = 2'(i);
      {lhi, llo} = 2'(3 - i);
      cfg(2'(i), 2'(3 - i), 1'b0);
    end
    for (int k = 0; k < 16; k++) begin
      if (k == 8) edge_s = 1'b1;
      rstep(1'(k + 1));
    end
    $display("test hardware straps done");
    wrap_up();
  end
endmodule

`default_nettype wire
